// ==== hdl/interlock_pkg.sv ====
// Purpose: shared constants and types for the drive enable interlock
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes: fault code is the drive's own event number
package interlock_pkg;
  localparam logic [7:0] FAULT_CODE_ENABLE = 8'h24; // fault 36
  localparam logic [7:0] FAULT_CODE_NONE = 8'h00; // no fault latched
  localparam logic FUNC_RUN = 1'h0;
  localparam logic FUNC_INHIBIT = 1'h1;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0]
  {
    ST_DISABLED = 3'h1,
    ST_ENABLED = 3'h2,
    ST_FAULTED = 3'h4
  } ilk_state_e;
endpackage : interlock_pkg

// ==== hdl/enable_sync_if.sv ====
// Purpose: carries the synchronised enable level between modules
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface enable_sync_if;
  logic level;
  modport src (output level);
  modport dst (input level);
endinterface : enable_sync_if
`default_nettype wire

// ==== hdl/enable_sync.sv ====
// Purpose: two-flop synchroniser for the enable/inhibit input pin
// Assumes: pin is asynchronous to clock
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module enable_sync
  import interlock_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic srst, // sync reset, active high
  input wire logic pin_in, // raw enable pin
  enable_sync_if.src sync // synchronised level
);
  logic [SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge clock)
  begin
    if (srst)
      stage_q <= '0;
    else
      stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
  end

  assign sync.level = stage_q[SYNC_STAGES-1];
endmodule : enable_sync
`default_nettype wire

// ==== hdl/drive_enable_interlock.sv ====
// Purpose: decides power-stage enable from pin, setting, program state, requests
// Assumes: requests are one-cycle pulses on clock; pin is asynchronous
// Notes: fault stays latched until fault_clear or a valid enable
// Operation
// - run setting, no program: input enables drive
// - run setting, program running: input inhibits only
// - inhibit setting: input is inhibit only
// - inhibit: requests enable only while input active
// - request with input inactive: reject, fault 36
// - input lost while enabled: disable, fault 36
`timescale 1ns/10ps
`default_nettype none
module drive_enable_interlock
  import interlock_pkg::*;
(
  input wire logic clock, // 200 MHz clock
  input wire logic srst, // sync reset, active high
  input wire logic enable_inhibit_input, // enable pin, high = active
  input wire logic enable_function, // 0 run, 1 inhibit
  input wire logic program_running, // user program executing
  input wire logic enable_request, // pulse from program or host
  input wire logic disable_request, // pulse from program or host
  input wire logic fault_clear, // pulse, clears latched fault
  output logic drive_enable, // power stage enable
  output logic fault_active, // latched fault flag
  output logic [7:0] fault_code, // code of latched fault
  output logic fault_event // one-cycle pulse when fault raised
);
  enable_sync_if sync_bus ();

  enable_sync u_sync
  (
    .clock(clock),
    .srst(srst),
    .pin_in(enable_inhibit_input),
    .sync(sync_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  logic pin_q;
  logic pin_prev_q;
  ilk_state_e state_q;
  ilk_state_e state_d;
  logic level_mode;
  logic req_ok;
  logic req_bad;
  logic pin_lost;
  logic raise_fault;

  // one decode shared by loss detection, enable output and fault release
  function automatic logic is_on(input ilk_state_e st);
    return st == ST_ENABLED;
  endfunction : is_on

  assign pin_q = sync_bus.level;

  always_ff @(posedge clock)
  begin
    if (srst)
      pin_prev_q <= 1'h0;
    else
      pin_prev_q <= pin_q;
  end

  // level mode only with run setting and no program
  assign level_mode = (enable_function == FUNC_RUN) && !program_running;
  assign req_ok = enable_request && pin_q && !level_mode;
  assign req_bad = enable_request && !pin_q;
  // loss is judged on the synchronised level, so a low caught at even one clock edge is enough to fault
  assign pin_lost = is_on(state_q) && !pin_q;
  assign raise_fault = req_bad || pin_lost;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_DISABLED, ST_FAULTED:
      begin
        if (level_mode && pin_q && !pin_prev_q)
          state_d = ST_ENABLED;
        else if (req_ok)
          state_d = ST_ENABLED;
        else if (req_bad)
          state_d = ST_FAULTED;
        else if (state_q == ST_FAULTED && fault_clear)
          state_d = ST_DISABLED;
      end
      ST_ENABLED:
      begin
        if (pin_lost)
          state_d = ST_FAULTED;
        else if (disable_request)
          state_d = ST_DISABLED;
      end
      default: state_d = ST_DISABLED;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state_q <= ST_DISABLED;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // taken from the next state so the pin cannot glitch the power stage
  always_ff @(posedge clock)
  begin
    if (srst)
      drive_enable <= 1'h0;
    else
      drive_enable <= is_on(state_d);
  end

  // set wins over clear in the same cycle, so a loss is never hidden by a clear
  always_ff @(posedge clock)
  begin
    if (srst)
      fault_active <= 1'h0;
    else if (raise_fault)
      fault_active <= 1'h1;
    else if (fault_clear || is_on(state_d))
      fault_active <= 1'h0;
  end

  // code follows the flag on the same edge
  always_ff @(posedge clock)
  begin
    if (srst)
      fault_code <= FAULT_CODE_NONE;
    else if (raise_fault)
      fault_code <= FAULT_CODE_ENABLE;
    else if (fault_clear || is_on(state_d))
      fault_code <= FAULT_CODE_NONE;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      fault_event <= 1'h0;
    else
      fault_event <= raise_fault;
  end

  ////////////////////////////////////////////////////////////////////////
  AST_LOSS_DISABLES: assert property (@(posedge clock) disable iff (srst)
    (drive_enable && !pin_q) |=> !drive_enable && fault_active && fault_code == FAULT_CODE_ENABLE)
    else $error("enable loss did not disable with fault");
  AST_BAD_REQ_FAULT: assert property (@(posedge clock) disable iff (srst)
    (enable_request && !pin_q) |=> !drive_enable && fault_active && fault_event)
    else $error("request without input not rejected");
  AST_INHIBIT_NO_SELF_ENABLE: assert property (@(posedge clock) disable iff (srst)
    (!drive_enable && enable_function == FUNC_INHIBIT && !enable_request) |=> !drive_enable)
    else $error("inhibit setting enabled without request");
  AST_PROG_NO_SELF_ENABLE: assert property (@(posedge clock) disable iff (srst)
    (!drive_enable && program_running && !enable_request) |=> !drive_enable)
    else $error("running program let input enable drive");
  AST_REQ_ENABLES: assert property (@(posedge clock) disable iff (srst)
    (enable_request && pin_q && !level_mode && !drive_enable) |=> drive_enable && !fault_active)
    else $error("valid request did not enable");
  AST_LEVEL_ENABLES: assert property (@(posedge clock) disable iff (srst)
    (level_mode && pin_q && !pin_prev_q && !drive_enable) |=> drive_enable)
    else $error("input edge did not enable in run mode");
  AST_ENABLE_NEEDS_PIN: assert property (@(posedge clock) disable iff (srst)
    $rose(drive_enable) |-> $past(pin_q))
    else $error("drive enabled with input inactive");
  AST_FAULT_HOLDS: assert property (@(posedge clock) disable iff (srst)
    (fault_active && !fault_clear && !enable_request && !(level_mode && pin_q)) |=> fault_active)
    else $error("fault dropped without clear or enable");

  ////////////////////////////////////////////////////////////////////////
  // output relations held on every cycle
  AST_RESET_QUIET: assert property (@(posedge clock)
    srst |=> !drive_enable && !fault_active && !fault_event && fault_code == FAULT_CODE_NONE)
    else $error("outputs not cleared by reset");
  AST_CODE_TRACKS_FLAG: assert property (@(posedge clock) disable iff (srst)
    fault_code == (fault_active ? FAULT_CODE_ENABLE : FAULT_CODE_NONE))
    else $error("fault code disagrees with fault flag");
  AST_EVENT_WITH_FLAG: assert property (@(posedge clock) disable iff (srst)
    fault_event |-> fault_active)
    else $error("fault pulse without latched fault");
  AST_INPUT_LOW_STAYS_OFF: assert property (@(posedge clock) disable iff (srst)
    !pin_q |=> !drive_enable)
    else $error("drive enabled while input inactive");

  // fault raising and release
  AST_NO_EVENT_WITHOUT_CAUSE: assert property (@(posedge clock) disable iff (srst)
    (!enable_request && !(drive_enable && !pin_q)) |=> !fault_event)
    else $error("fault raised with no cause");
  AST_LOSS_BEATS_CLEAR: assert property (@(posedge clock) disable iff (srst)
    (fault_clear && drive_enable && !pin_q) |=> fault_active && !drive_enable)
    else $error("clear hid a loss fault");
  AST_PROG_LOSS_FAULTS: assert property (@(posedge clock) disable iff (srst)
    (program_running && drive_enable && !pin_q) |=> fault_event && !drive_enable)
    else $error("loss with program running not faulted");
  AST_CLEAR_DROPS_FAULT: assert property (@(posedge clock) disable iff (srst)
    (fault_clear && !enable_request && !(drive_enable && !pin_q)) |=> !fault_active)
    else $error("clear did not drop fault");
  AST_CLEAR_NO_ENABLE: assert property (@(posedge clock) disable iff (srst)
    (fault_clear && !enable_request && !level_mode && !drive_enable) |=> !drive_enable)
    else $error("clear alone enabled drive");

  // request handling by setting
  AST_RUN_REQ_IGNORED: assert property (@(posedge clock) disable iff (srst)
    (level_mode && enable_request && pin_q && pin_prev_q && !drive_enable) |=> !drive_enable && !fault_event)
    else $error("request acted on while input governs");
  AST_INHIBIT_REQ_ENABLES: assert property (@(posedge clock) disable iff (srst)
    (enable_function == FUNC_INHIBIT && enable_request && pin_q && !drive_enable) |=> drive_enable)
    else $error("inhibit setting refused valid request");

  COV_LEVEL_ENABLE: cover property (@(posedge clock) disable iff (srst)
    level_mode && pin_q ##1 drive_enable);
  COV_REQ_ENABLE: cover property (@(posedge clock) disable iff (srst) req_ok ##1 drive_enable);
  COV_LOSS: cover property (@(posedge clock) disable iff (srst) drive_enable ##1 !drive_enable && fault_active);
  COV_BAD_REQ: cover property (@(posedge clock) disable iff (srst) req_bad);
  COV_CLEAR: cover property (@(posedge clock) disable iff (srst) fault_active && fault_clear ##1 !fault_active);
endmodule : drive_enable_interlock
`default_nettype wire

// ==== testbench/switch_model.sv ====
// Purpose: enable switch and user program status
// Assumes: moves only at falling clock edge
// Notes: random byte steers both
`timescale 1ns/10ps
`default_nettype none
module switch_model
(
  input wire logic clock, // bench clock
  input wire logic hold, // forces switch open
  input wire logic [7:0] rnd, // random byte
  output logic pin, // switch level
  output logic prog // program running
);
  always @(negedge clock)
  begin
    if (hold)
    begin
      pin <= 1'h0;
      prog <= 1'h0;
    end
    else
    begin
      if (rnd[7:5] == 3'h0)
        pin <= ~pin;
      if (rnd[4:0] == 5'h1F)
        prog <= ~prog;
    end
  end
endmodule : switch_model
`default_nettype wire

// ==== testbench/drive_enable_interlock_bench.sv ====
// Purpose: random check of the interlock against a cycle model
// Assumes: requests, disables and clears arrive under either setting
// Notes: compares at every falling edge out of reset
`timescale 1ns/10ps
`default_nettype none
module drive_enable_interlock_bench;
  import interlock_pkg::*;
  logic clock, srst, hold, pin, func, prog, en_req, dis_req, clr, drive_enable, fault_active, fault_event;
  logic [7:0] fault_code, rnd;
  int err_count, cmp_count, s1, s2, qp, m_en, m_flt, m_evt, go;
  drive_enable_interlock i_dut (.clock(clock), .srst(srst), .enable_inhibit_input(pin), .enable_function(func),
    .program_running(prog), .enable_request(en_req), .disable_request(dis_req), .fault_clear(clr),
    .drive_enable(drive_enable), .fault_active(fault_active), .fault_code(fault_code), .fault_event(fault_event));
  switch_model i_sw (.clock(clock), .hold(hold), .rnd(rnd), .pin(pin), .prog(prog));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic chk_code(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED fault_code expected %h seen %h", exp, got);
    end
  endtask : chk_code
  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  // reference: two-stage sync, then decision on synced level
  always @(posedge clock)
  begin
    if (srst)
    begin
      s1 = 0;
      s2 = 0;
      qp = 0;
      m_en = 0;
      m_flt = 0;
      m_evt = 0;
    end
    else
    begin
      go = (func == FUNC_INHIBIT || prog) ? (en_req && s2) : (s2 && !qp);
      m_evt = (en_req || m_en) && !s2;
      if (m_evt || clr || go)
        m_flt = m_evt;
      if (m_evt || (m_en && dis_req))
        m_en = 0;
      else if (go)
        m_en = 1;
      qp = s2;
      s2 = s1;
      s1 = pin;
    end
  end
  task automatic step();
    chk_bit("drive_enable", m_en[0], drive_enable);
    chk_bit("fault_active", m_flt[0], fault_active);
    chk_bit("fault_event", m_evt[0], fault_event);
    chk_code(m_flt[0] ? FAULT_CODE_ENABLE : 8'h00, fault_code);
    rnd <= lfsr(rnd);
    if (rnd == 8'hA5 || rnd == 8'h5B)
      func = ~func;
    en_req = rnd[3:0] == 4'h6;
    dis_req = rnd[3:0] == 4'h9;
    clr = rnd[7:4] == 4'hC;
  endtask : step
  ////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    {srst, hold} = 2'h3;
    {func, en_req, dis_req, clr} = 4'h0;
    rnd = 8'h3A;
    repeat (16) @(negedge clock);
    repeat (2)
    begin
      {srst, hold} = 2'b00;
      repeat (3000)
      begin
        @(negedge clock);
        step();
      end
      {srst, hold} = 2'h3;
      repeat (3) @(negedge clock);
    end
    give_verdict();
  end
  // hang guard, well past the expected 6000 cycles
  initial
  begin
    #40000;
    err_count++;
    give_verdict();
  end
endmodule : drive_enable_interlock_bench
`default_nettype wire
